/* File: bench/serial_flash_command_engine_tb_top.sv */
// self-checking bench: host and device ends joined by one link
// assumes host user port as in its hand-over; write-protect pin held high
`timescale 1ns/1ps
module serial_flash_command_engine_tb_top;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  opc = 8'h00;
  logic [23:0] adr = 24'h00_0000;
  logic [2:0]  alen = 3'h0;
  logic [8:0]  wlen = 9'h000;
  logic [15:0] rlen = 16'h0000;
  logic [7:0]  wr_data = 8'h00;
  logic        wr_valid = 1'b0;
  logic        ready, wr_ready, rd_valid, busy, write_latch_flag, sleeping;
  logic [7:0]  rd_data;
  logic [2:0]  bp;
  logic [7:0]  wq[$];
  logic [7:0]  rq[$];
  int          error_cnt = 0;
  int          checks = 0;
  localparam logic [7:0] SIG = 8'hC3; // arbitrary signature value

  sfc_link_if link ();
  sfc_host sfc_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .link(link.host), .i_start(start), .i_opcode(opc), .i_addr(adr),
    .i_alen(alen), .i_wlen(wlen), .i_rlen(rlen), .o_ready(ready),
    .i_wr_data(wr_data), .i_wr_valid(wr_valid), .o_wr_ready(wr_ready),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid));
  sfc_device #(.CHIP_CYCS(8200), .SIG_CODE(SIG)) sfc_device_inst (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n), .link(link.dev), .i_wp_n(1'b1),
    .o_cycle_active_flag(busy), .o_write_latch_flag(write_latch_flag),
    .o_sleeping(sleeping), .o_protect_bits(bp));
  sfc_link_assertions sfc_link_assertions_inst (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .cs_n(link.cs_n), .sck(link.sck),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .o_cycle_active_flag(busy),
    .o_write_latch_flag(write_latch_flag), .o_sleeping(sleeping));

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one command: write bytes come from wq, read bytes land in rq
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input logic [2:0] al, input logic [15:0] rl);
    int k;
    k = 0;
    rq.delete();
    while (ready !== 1'b1) @(posedge i_clk);
    #1 start = 1'b1;
    opc = op;
    adr = a;
    alen = al;
    rlen = rl;
    wlen = 9'(wq.size());
    @(posedge i_clk);
    #1 start = 1'b0;
    repeat (20000) begin
      wr_valid = (k < wq.size());
      if (k < wq.size()) wr_data = wq[k];
      @(posedge i_clk);
      if (wr_ready === 1'b1 && wr_valid) k++;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (ready === 1'b1) break;
      #1;
    end
    wr_valid = 1'b0;
    wq.delete();
  endtask

  task automatic wait_idle();
    repeat (12000) begin
      @(posedge i_clk);
      if (busy === 1'b0) break;
    end
    chk(busy, 1'b0);
  endtask

  task automatic rd1(input logic [23:0] a, input logic [7:0] exp);
    cmd(sfc_pkg::OP_FAST, a, 3'h4, 16'h0001);
    chk(rq[0], exp);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    repeat (6) @(posedge i_clk);
    cmd(sfc_pkg::OP_BE, 24'h00_0000, 3'h0, 16'h0000);
    chk(busy, 1'b1);
    chk(write_latch_flag, 1'b0);
    wait_idle();
    wq = '{8'hA5, 8'h3C, 8'h0F};
    cmd(sfc_pkg::OP_PP, 24'h00_00FE, 3'h3, 16'h0000);
    wait_idle();
    wq = '{8'hF0};
    cmd(sfc_pkg::OP_PP, 24'h00_0000, 3'h3, 16'h0000);
    wait_idle();
    cmd(sfc_pkg::OP_FAST, 24'h00_00FD, 3'h4, 16'h0004);
    chk(rq[0], 8'hFF);
    chk(rq[1], 8'hA5);
    chk(rq[2], 8'h3C);
    chk(rq[3], 8'hFF);
    cmd(sfc_pkg::OP_FAST, 24'hFF_FFFF, 3'h4, 16'h0002);
    chk(rq[0], 8'hFF);
    chk(rq[1], 8'h00);
    cmd(sfc_pkg::OP_SE, 24'h00_0123, 3'h3, 16'h0000);
    chk(write_latch_flag, 1'b0);
    wait_idle();
    rd1(24'h00_0000, 8'hFF);
    // sleep blocks programming until release
    cmd(sfc_pkg::OP_DP, 24'h00_0000, 3'h0, 16'h0000);
    repeat (400) @(posedge i_clk);
    chk(sleeping, 1'b1);
    wq = '{8'h00};
    cmd(sfc_pkg::OP_PP, 24'h00_0200, 3'h3, 16'h0000);
    chk(busy, 1'b0);
    cmd(sfc_pkg::OP_RES, 24'h00_0000, 3'h1, 16'h0000);
    chk(sleeping, 1'b1);
    cmd(sfc_pkg::OP_RES, 24'h00_0000, 3'h0, 16'h0000);
    chk(sleeping, 1'b0);
    rd1(24'h00_0200, 8'hFF);
    cmd(sfc_pkg::OP_RES, 24'h00_0000, 3'h3, 16'h0001);
    chk(rq[0], SIG);
    // top sector protected
    wq = '{8'h04};
    cmd(sfc_pkg::OP_WRSR, 24'h00_0000, 3'h0, 16'h0000);
    wait_idle();
    chk(bp, 3'h1);
    wq = '{8'h00};
    cmd(sfc_pkg::OP_PP, 24'h00_1C10, 3'h3, 16'h0000);
    chk(busy, 1'b0);
    rd1(24'h00_1C10, 8'hFF);
    cmd(sfc_pkg::OP_SE, 24'h00_1C00, 3'h3, 16'h0000);
    chk(busy, 1'b0);
    cmd(sfc_pkg::OP_BE, 24'h00_0000, 3'h0, 16'h0000);
    chk(busy, 1'b0);
    chk(write_latch_flag, 1'b1);
    cmd(sfc_pkg::OP_WRDI, 24'h00_0000, 3'h0, 16'h0000);
    chk(write_latch_flag, 1'b0);
    wq = '{8'h00};
    cmd(sfc_pkg::OP_WRSR, 24'h00_0000, 3'h0, 16'h0000);
    wait_idle();
    chk(bp, 3'h0);
    // read and sleep refused while programming
    wq = '{8'h55};
    cmd(sfc_pkg::OP_PP, 24'h00_0300, 3'h3, 16'h0000);
    rd1(24'h00_0300, 8'hFF);
    cmd(sfc_pkg::OP_DP, 24'h00_0000, 3'h0, 16'h0000);
    repeat (400) @(posedge i_clk);
    chk(sleeping, 1'b0);
    chk(busy, 1'b1);
    cmd(sfc_pkg::OP_RDSR, 24'h00_0000, 3'h0, 16'h0001);
    chk(rq[0], 8'h01);
    wait_idle();
    rd1(24'h00_0300, 8'h55);
    tally_and_finish();
  end

  // watchdog against a hung handshake
  initial begin
    #900000;
    error_cnt++;
    tally_and_finish();
  end
endmodule

/* File: bench/sfc_link_assertions.sv */
// link checker for the serial flash command engine
// assumes the bench wires it beside the one link between both ends
`timescale 1ns/1ps
module sfc_link_assertions (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic o_cycle_active_flag,
  input wire logic o_write_latch_flag,
  input wire logic o_sleeping
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // link timing: clock idle, data moves only while the clock is low
  AST_SCK_IDLE: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("link clock moves while deselected");
  AST_IN_ON_LOW: assert property ($changed(serial_in) |-> !sck)
    else $error("input data changes while clock high");
  AST_OUT_ON_LOW: assert property (
    serial_out_oe && $changed(serial_out) |-> !sck)
    else $error("output data changes while clock high");
  AST_OE_DROPS: assert property (
    $rose(cs_n) |-> ##[0:4] !serial_out_oe)
    else $error("output still driven after deselect");
  // self-timed cycles
  AST_BUSY_AFTER_CS: assert property (
    $rose(o_cycle_active_flag) |-> cs_n)
    else $error("cycle started while selected");
  AST_BUSY_HOLDS: assert property (
    $rose(o_cycle_active_flag) |=> o_cycle_active_flag [*8])
    else $error("cycle flag too short");
  AST_LATCH_CLEARS: assert property (
    $rose(o_cycle_active_flag) |-> ##[0:3] !o_write_latch_flag)
    else $error("write latch not cleared in cycle");
  AST_NOT_ASLEEP: assert property (
    $rose(o_cycle_active_flag) |-> !o_sleeping)
    else $error("cycle started while asleep");
  AST_SLEEP_IDLE: assert property (
    $rose(o_sleeping) |-> !o_cycle_active_flag)
    else $error("sleep entered during cycle");
  // main scenarios reached
  cover property ($rose(o_cycle_active_flag));
  cover property ($rose(o_sleeping));
  cover property ($rose(serial_out_oe));
endmodule

/* File: rtl/sfc_device.sv */
// flash device end: command decode, read, program, erase, power-down
// assumes link pins come from another clock domain; sck idles low
// How it works
// - fast read: opcode, address, dummy, then data
// - sample on sck rise, drive on fall
// - read address increments, wraps at top
// - select high ends read anywhere
// - fast read ignored during busy cycle
// - programming only clears bits
// - program needs write latch and data
// - program data wraps within page
// - last 256 bytes win, rest untouched
// - program needs select rise on byte boundary
// - timed program, busy flag, latch cleared
// - protected page is not programmed
// - sector erase to FFh, needs latch
// - erase runs only after exactly four bytes
// - protected sector is not erased
// - bulk erase: single byte, timed, FFh
// - bulk erase only with protection off
// - power-down after delay, blocks writes
// - power-down refused during busy cycle
// - only release or signature wakes device
// - extra clocks reject release
// - standby after wake delay, host waits
// - protect bits size the shielded region
`timescale 1ns/1ps
module sfc_device #(
  parameter logic [7:0]  SIG_CODE  = 8'h5A, // arbitrary signature value
  parameter int unsigned CHIP_CYCS = sfc_pkg::CHIP_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  sfc_link_if.dev         link,
  input  wire logic       i_wp_n,
  output logic            o_cycle_active_flag,
  output logic            o_write_latch_flag,
  output logic            o_sleeping,
  output logic [2:0]      o_protect_bits
);
  localparam int unsigned AW = sfc_pkg::MEM_AW;
  typedef struct packed {
    logic [2:0]       cs_sy;
    logic [2:0]       sck_sy;
    logic [1:0]       si_sy;
    logic [1:0]       wp_sy;
    logic [2:0]       bitc;
    logic [2:0]       nby;
    logic [7:0]       sr;
    logic [7:0]       cmd;
    logic [23:0]      addr;
    logic [7:0]       wsr;
    logic [255:0]     pmask;
    logic [7:0]       osr;
    logic             so;
    logic             oe;
    sfc_pkg::sfc_bop_t op;
    logic [15:0]      bcnt;
    logic [AW-1:0]    lp;
    logic [13:0]      lrem;
    logic             write_latch_flag;
    logic             srwd;
    logic [2:0]       bp;
    logic             sleep;
    sfc_pkg::sfc_pw_t pend;
    logic [15:0]      dcnt;
  } sfc_dev_st_t;

  sfc_dev_st_t q;
  sfc_dev_st_t nxt_q;
  logic [7:0]    mem  [2**AW];
  logic [7:0]    pbuf [256];
  logic          mem_we;
  logic [7:0]    mem_wd;
  logic [7:0]    mem_rd;
  logic [7:0]    pb_rd;
  logic          pb_we;
  logic [7:0]    b;
  logic          sck_rise;
  logic          sck_fall;
  logic          cs_rise;
  logic          busy;
  logic          ok8;
  logic          fast_pref;
  logic          fast_out;
  logic          st_out;
  logic          sig_out;
  logic [7:0]    status;
  logic [7:0]    src;
  logic          f_in_ready;
  logic          f_out_valid;
  logic          f_out_ready;
  logic [7:0]    f_out_data;

  // protected when the sector lies in the top region sized by the bits
  function automatic logic prot(input logic [2:0] bp,
                                input logic [AW-1:0] a);
    logic [3:0] n;
    n = (bp == 3'h0) ? 4'h0 :
        (bp >= 3'h4) ? sfc_pkg::NSECT : 4'h1 << (bp - 3'h1);
    return ({1'b0, a[AW-1:sfc_pkg::SECT_AW]} + n) >= sfc_pkg::NSECT;
  endfunction

  // edges seen on the synchronised pins
  assign sck_rise = q.sck_sy[1] & ~q.sck_sy[2];
  assign sck_fall = ~q.sck_sy[1] & q.sck_sy[2];
  assign cs_rise  = q.cs_sy[1] & ~q.cs_sy[2];
  assign busy     = (q.op != sfc_pkg::BOP_NONE);
  assign ok8      = (q.bitc == 3'h0);
  assign b        = {q.sr[6:0], q.si_sy[1]}; // msb first
  assign status   = {q.srwd, 2'h0, q.bp, q.write_latch_flag, busy};
  // output sources, each only in its own command and phase
  assign fast_pref = ~q.cs_sy[1] & (q.cmd == sfc_pkg::OP_FAST)
                     & (q.nby >= 3'h4) & ~busy & ~q.sleep;
  assign fast_out  = fast_pref & (q.nby >= 3'h5);
  assign st_out    = (q.cmd == sfc_pkg::OP_RDSR) & (q.nby != 3'h0)
                     & ~q.sleep;
  assign sig_out   = (q.cmd == sfc_pkg::OP_RES) & (q.nby >= 3'h4) & ~busy;
  assign src = st_out ? status : sig_out ? SIG_CODE :
               (f_out_valid ? f_out_data : 8'hFF);
  assign mem_rd = mem[busy ? q.lp : q.addr[AW-1:0]];
  assign pb_rd  = pbuf[q.lp[7:0]];

  // read-ahead buffer between array and output shifter
  sfc_fifo #(
    .W (sfc_pkg::FIFO_W),
    .D (sfc_pkg::FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_clear     (q.cs_sy[1]),
    .i_in_data   (mem_rd),
    .i_in_valid  (fast_pref),
    .o_in_ready  (f_in_ready),
    .o_out_data  (f_out_data),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_out_ready)
  );

  // next state: link shifting, frame-end decode, timed cycles
  always_comb begin
    nxt_q = q;
    mem_we = 1'b0;
    mem_wd = 8'hFF;
    pb_we = 1'b0;
    f_out_ready = 1'b0;
    nxt_q.cs_sy  = {q.cs_sy[1:0], link.cs_n};
    nxt_q.sck_sy = {q.sck_sy[1:0], link.sck};
    nxt_q.si_sy  = {q.si_sy[0], link.serial_in};
    nxt_q.wp_sy  = {q.wp_sy[0], i_wp_n};
    if (q.cs_sy[1]) begin
      nxt_q.bitc = 3'h0;
      nxt_q.nby = 3'h0;
      nxt_q.oe = 1'b0;
    end else begin
      if (sck_rise) begin
        nxt_q.sr = b;
        nxt_q.bitc = q.bitc + 3'h1;
        if (q.bitc == 3'h7) begin
          if (q.nby != 3'h7) nxt_q.nby = q.nby + 3'h1;
          if (q.nby == 3'h0) begin
            nxt_q.cmd = b;
            if (!busy && b == sfc_pkg::OP_PP) nxt_q.pmask = '0;
          end else if (q.nby <= 3'h3) begin
            nxt_q.addr = {q.addr[15:0], b};
          end else if (q.cmd == sfc_pkg::OP_PP && !busy) begin
            pb_we = 1'b1; // later bytes overwrite earlier
            nxt_q.pmask[q.addr[7:0]] = 1'b1;
            nxt_q.addr[7:0] = q.addr[7:0] + 8'h01;
          end
          if (q.nby == 3'h1) nxt_q.wsr = b;
        end
      end
      if (fast_pref && f_in_ready) nxt_q.addr = q.addr + 24'h00_0001;
      if (sck_fall) begin
        if (ok8) begin
          if (fast_out || st_out || sig_out) begin
            nxt_q.oe = 1'b1;
            nxt_q.so = src[7];
            nxt_q.osr = {src[6:0], 1'b0};
            f_out_ready = fast_out;
          end
        end else begin
          nxt_q.so = q.osr[7];
          nxt_q.osr = {q.osr[6:0], 1'b0};
        end
      end
    end
    // timed cycle: one array byte per clock, then wait out the count
    if (busy) begin
      nxt_q.bcnt = q.bcnt - 16'h0001;
      if (q.bcnt == 16'h0001) nxt_q.op = sfc_pkg::BOP_NONE;
      if (q.lrem != 14'h0) begin
        nxt_q.lp = q.lp + 1'b1;
        nxt_q.lrem = q.lrem - 14'h1;
        mem_we = (q.op != sfc_pkg::BOP_PP) | q.pmask[q.lp[7:0]];
        if (q.op == sfc_pkg::BOP_PP) mem_wd = mem_rd & pb_rd;
      end
    end
    // power-down entry and wake delays
    if (q.pend != sfc_pkg::PW_NONE) begin
      nxt_q.dcnt = q.dcnt - 16'h0001;
      if (q.dcnt == 16'h0001) begin
        nxt_q.pend = sfc_pkg::PW_NONE;
        nxt_q.sleep = (q.pend == sfc_pkg::PW_ENTER);
      end
    end
    // command execution when select rises
    if (cs_rise) begin
      if (q.sleep) begin
        if (q.pend == sfc_pkg::PW_NONE && !busy && q.nby != 3'h0
            && q.cmd == sfc_pkg::OP_RES
            && ((q.nby == 3'h1 && ok8) || q.nby >= 3'h4)) begin
          nxt_q.pend = sfc_pkg::PW_WAKE;
          nxt_q.dcnt = 16'(sfc_pkg::WAKE_CYC);
        end
      end else if (!busy && q.pend == sfc_pkg::PW_NONE && q.nby != 3'h0
                   && ok8) begin
        if (q.cmd == sfc_pkg::OP_WREN && q.nby == 3'h1) begin
          nxt_q.write_latch_flag = 1'b1;
        end else if (q.cmd == sfc_pkg::OP_WRDI && q.nby == 3'h1) begin
          nxt_q.write_latch_flag = 1'b0;
        end else if (q.cmd == sfc_pkg::OP_PP && q.nby >= 3'h5 && q.write_latch_flag
                     && !prot(q.bp, q.addr[AW-1:0])) begin
          nxt_q.op = sfc_pkg::BOP_PP;
          nxt_q.bcnt = 16'(sfc_pkg::PROG_CYC);
          nxt_q.lp = {q.addr[AW-1:8], 8'h00};
          nxt_q.lrem = sfc_pkg::PAGE_SZ;
          nxt_q.write_latch_flag = 1'b0;
        end else if (q.cmd == sfc_pkg::OP_SE && q.nby == 3'h4 && q.write_latch_flag
                     && !prot(q.bp, q.addr[AW-1:0])) begin
          nxt_q.op = sfc_pkg::BOP_SE;
          nxt_q.bcnt = 16'(sfc_pkg::SECT_CYC);
          nxt_q.lp = {q.addr[AW-1:sfc_pkg::SECT_AW],
                      sfc_pkg::SECT_AW'(0)};
          nxt_q.lrem = sfc_pkg::SECT_SZ;
          nxt_q.write_latch_flag = 1'b0;
        end else if (q.cmd == sfc_pkg::OP_BE && q.nby == 3'h1 && q.write_latch_flag
                     && q.bp == 3'h0) begin
          nxt_q.op = sfc_pkg::BOP_BE;
          nxt_q.bcnt = 16'(CHIP_CYCS);
          nxt_q.lp = '0;
          nxt_q.lrem = sfc_pkg::ARR_SZ;
          nxt_q.write_latch_flag = 1'b0;
        end else if (q.cmd == sfc_pkg::OP_WRSR && q.nby == 3'h2 && q.write_latch_flag
                     && !(q.srwd && !q.wp_sy[1])) begin
          nxt_q.op = sfc_pkg::BOP_WSR;
          nxt_q.bcnt = 16'(sfc_pkg::WSR_CYC);
          nxt_q.lrem = 14'h0;
          nxt_q.srwd = q.wsr[7];
          nxt_q.bp = q.wsr[4:2];
          nxt_q.write_latch_flag = 1'b0;
        end else if (q.cmd == sfc_pkg::OP_DP && q.nby == 3'h1) begin
          nxt_q.pend = sfc_pkg::PW_ENTER;
          nxt_q.dcnt = 16'(sfc_pkg::SLEEP_CYC);
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.cs_sy <= 3'h7;
      q.bp <= sfc_pkg::BP_RST;
      q.srwd <= sfc_pkg::SRWD_RST;
    end else begin
      q <= nxt_q;
    end
  end

  // array and page buffer writes
  always_ff @(posedge i_clk) begin
    if (mem_we) mem[q.lp] <= mem_wd;
    if (pb_we) pbuf[q.addr[7:0]] <= b;
  end

  assign link.serial_out    = q.so;
  assign link.serial_out_oe = q.oe;
  assign o_cycle_active_flag = busy;
  assign o_write_latch_flag  = q.write_latch_flag;
  assign o_sleeping          = q.sleep;
  assign o_protect_bits      = q.bp;
endmodule

/* File: rtl/sfc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock; i_clear empties it at once
`timescale 1ns/1ps
module sfc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clear,
  input  wire logic [W-1:0] i_in_data,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  output logic [W-1:0]      o_out_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sfc_fifo_st_t;

  sfc_fifo_st_t q;
  sfc_fifo_st_t nxt_q;
  logic [W-1:0] store [D];
  logic         push;
  logic         pop;

  // honest full and empty from the fill count
  assign o_in_ready  = (q.cnt != (AW+1)'(D));
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = store[q.rp];
  assign push = i_in_valid & o_in_ready;
  assign pop  = i_out_ready & o_out_valid;

  // pointer and count update
  always_comb begin
    nxt_q = q;
    if (push) nxt_q.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
    if (pop) nxt_q.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
    nxt_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (i_clear) nxt_q = '0;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) q <= '0;
    else q <= nxt_q;
  end

  // storage words
  always_ff @(posedge i_clk) begin
    if (push) store[q.wp] <= i_in_data;
  end
endmodule

/* File: rtl/sfc_host.sv */
// host end: frames one command over the link and returns read bytes
// assumes the user waits for o_ready before i_start
`timescale 1ns/1ps
module sfc_host (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  sfc_link_if.host         link,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [23:0] i_addr,
  input  wire logic [2:0]  i_alen,
  input  wire logic [8:0]  i_wlen,
  input  wire logic [15:0] i_rlen,
  output logic             o_ready,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_valid,
  output logic             o_wr_ready,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid
);
  typedef struct packed {
    sfc_pkg::sfc_hst_t st;
    logic        pre;
    logic [3:0]  div;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic [2:0]  bitc;
    logic [2:0]  hidx;
    logic [2:0]  hcnt;
    logic [8:0]  wrem;
    logic [15:0] rrem;
    logic        rdph;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  alen;
    logic [8:0]  wlen;
    logic [15:0] rlen;
    logic [15:0] gap;
    logic [1:0]  miso_sy;
    logic [7:0]  rd_data;
    logic        rd_valid;
  } sfc_host_st_t;

  sfc_host_st_t q;
  sfc_host_st_t nxt_q;
  logic [7:0]   hbyte;

  // header byte: opcode, three address bytes, dummy
  always_comb begin
    case (q.hidx)
      3'h0:    hbyte = q.pre ? sfc_pkg::OP_WREN : q.op;
      3'h1:    hbyte = q.addr[23:16];
      3'h2:    hbyte = q.addr[15:8];
      3'h3:    hbyte = q.addr[7:0];
      default: hbyte = 8'h00;
    endcase
  end

  // frame sequencing and clock divider
  always_comb begin
    nxt_q = q;
    o_wr_ready = 1'b0;
    nxt_q.rd_valid = 1'b0;
    nxt_q.miso_sy = {q.miso_sy[0], link.serial_line};
    case (q.st)
      sfc_pkg::HS_IDLE: begin
        if (i_start) begin
          nxt_q.op = i_opcode;
          nxt_q.addr = i_addr;
          nxt_q.alen = i_alen;
          nxt_q.wlen = i_wlen;
          nxt_q.rlen = i_rlen;
          // latch-setting frame goes first
          nxt_q.pre = (i_opcode == sfc_pkg::OP_PP)
                      || (i_opcode == sfc_pkg::OP_SE)
                      || (i_opcode == sfc_pkg::OP_BE)
                      || (i_opcode == sfc_pkg::OP_WRSR);
          nxt_q.hidx = 3'h0;
          nxt_q.hcnt = nxt_q.pre ? 3'h1 : i_alen + 3'h1;
          nxt_q.wrem = nxt_q.pre ? 9'h0 : i_wlen;
          nxt_q.rrem = nxt_q.pre ? 16'h0 : i_rlen;
          nxt_q.cs_n = 1'b0;
          nxt_q.st = sfc_pkg::HS_LOAD;
        end
      end
      sfc_pkg::HS_LOAD: begin
        nxt_q.div = 4'h0;
        nxt_q.bitc = 3'h0;
        if (q.hcnt != 3'h0) begin
          nxt_q.tx = hbyte;
          nxt_q.hcnt = q.hcnt - 3'h1;
          nxt_q.hidx = q.hidx + 3'h1;
          nxt_q.rdph = 1'b0;
          nxt_q.st = sfc_pkg::HS_SHIFT;
        end else if (q.wrem != 9'h0) begin
          o_wr_ready = 1'b1;
          if (i_wr_valid) begin
            nxt_q.tx = i_wr_data;
            nxt_q.wrem = q.wrem - 9'h1;
            nxt_q.rdph = 1'b0;
            nxt_q.st = sfc_pkg::HS_SHIFT;
          end
        end else if (q.rrem != 16'h0) begin
          nxt_q.tx = 8'h00;
          nxt_q.rrem = q.rrem - 16'h1;
          nxt_q.rdph = 1'b1;
          nxt_q.st = sfc_pkg::HS_SHIFT;
        end else begin
          // select rises only on a byte boundary
          nxt_q.cs_n = 1'b1;
          nxt_q.gap = (q.op == sfc_pkg::OP_RES && !q.pre)
                      ? 16'(sfc_pkg::WAKE_CYC) + sfc_pkg::GAP_CYC
                      : sfc_pkg::GAP_CYC;
          nxt_q.st = sfc_pkg::HS_GAP;
        end
        nxt_q.mosi = nxt_q.tx[7];
      end
      sfc_pkg::HS_SHIFT: begin
        nxt_q.div = q.div + 4'h1;
        if (q.div == sfc_pkg::HALF_CYC - 4'h1) begin
          nxt_q.div = 4'h0;
          nxt_q.sck = ~q.sck;
          if (q.sck) begin
            nxt_q.rx = {q.rx[6:0], q.miso_sy[1]};
            nxt_q.bitc = q.bitc + 3'h1;
            nxt_q.tx = {q.tx[6:0], 1'b0};
            nxt_q.mosi = q.tx[6];
            if (q.bitc == 3'h7) begin
              nxt_q.rd_data = {q.rx[6:0], q.miso_sy[1]};
              nxt_q.rd_valid = q.rdph;
              nxt_q.st = sfc_pkg::HS_LOAD;
            end
          end
        end
      end
      default: begin
        nxt_q.gap = q.gap - 16'h1;
        if (q.gap == 16'h1) begin
          if (q.pre) begin
            nxt_q.pre = 1'b0;
            nxt_q.hidx = 3'h0;
            nxt_q.hcnt = q.alen + 3'h1;
            nxt_q.wrem = q.wlen;
            nxt_q.rrem = q.rlen;
            nxt_q.cs_n = 1'b0;
            nxt_q.st = sfc_pkg::HS_LOAD;
          end else begin
            nxt_q.st = sfc_pkg::HS_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
      q.cs_n <= 1'b1;
    end else begin
      q <= nxt_q;
    end
  end

  assign link.cs_n      = q.cs_n;
  assign link.sck       = q.sck;
  assign link.serial_in = q.mosi;
  assign o_ready    = (q.st == sfc_pkg::HS_IDLE);
  assign o_rd_data  = q.rd_data;
  assign o_rd_valid = q.rd_valid;
endmodule

/* File: rtl/sfc_link_if.sv */
// serial link between host controller and flash device
// assumes the bench connects both modports to one instance
`timescale 1ns/1ps
interface sfc_link_if;
  logic cs_n;
  logic sck;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic serial_line;

  // released line reads high, as through a pull-up
  assign serial_line = serial_out_oe ? serial_out : 1'b1;

  modport dev (
    input  cs_n,
    input  sck,
    input  serial_in,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output cs_n,
    output sck,
    output serial_in,
    input  serial_line
  );
endinterface

/* File: rtl/sfc_pkg.sv */
// shared constants and types of the serial flash command engine
// assumes a 100 MHz system clock on both ends
package sfc_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // command opcodes, sent msb first
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_PP   = 8'h02;
  localparam logic [7:0] OP_SE   = 8'hD8;
  localparam logic [7:0] OP_BE   = 8'hC7;
  localparam logic [7:0] OP_DP   = 8'hB9;
  localparam logic [7:0] OP_RES  = 8'hAB;
  // array geometry: 8 sectors of 1 KiB, 256-byte pages
  localparam int unsigned MEM_AW  = 13;
  localparam int unsigned SECT_AW = 10;
  localparam logic [3:0]  NSECT   = 4'h8;
  localparam logic [13:0] PAGE_SZ = 14'h0100;
  localparam logic [13:0] SECT_SZ = 14'h0400;
  localparam logic [13:0] ARR_SZ  = 14'h2000;
  // self-timed delays in ns, and their cycle counts
  localparam int unsigned PROG_TIME_NS  = 30000;
  localparam int unsigned SECT_TIME_NS  = 20000;
  localparam int unsigned CHIP_TIME_NS  = 100000;
  localparam int unsigned WSR_TIME_NS   = 10000;
  localparam int unsigned SLEEP_TIME_NS = 3000;
  localparam int unsigned WAKE_TIME_NS  = 3000;
  localparam int unsigned PROG_CYC  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SECT_CYC  = (SECT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CHIP_CYC  = (CHIP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WSR_CYC   = (WSR_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLEEP_CYC = (SLEEP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_CYC  = (WAKE_TIME_NS * CLK_MHZ + 999) / 1000;
  // reset values of the protection bits
  localparam logic [2:0] BP_RST   = 3'h0;
  localparam logic       SRWD_RST = 1'b0;
  // read-ahead buffer
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 4;
  // host link timing: half clock period and deselect gap in cycles
  localparam logic [3:0]  HALF_CYC = 4'h8;
  localparam logic [15:0] GAP_CYC  = 16'h0014;

  typedef enum logic [2:0] {
    BOP_NONE = 3'b000,
    BOP_PP   = 3'b001,
    BOP_SE   = 3'b010,
    BOP_BE   = 3'b011,
    BOP_WSR  = 3'b100
  } sfc_bop_t;

  typedef enum logic [1:0] {
    PW_NONE  = 2'b00,
    PW_ENTER = 2'b01,
    PW_WAKE  = 2'b10
  } sfc_pw_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_LOAD  = 2'b01,
    HS_SHIFT = 2'b10,
    HS_GAP   = 2'b11
  } sfc_hst_t;
endpackage
